// File: febo_defs.svh
`ifndef FEBO_DEFS_SVH
`define FEBO_DEFS_SVH

// Register offsets on the plain register port
`define FEBO_ADDR_W 4
`define FEBO_OFF_EBSEL_LO 4'h0
`define FEBO_OFF_EBSEL_HI 4'h1
`define FEBO_OFF_OVL_CTRL 4'h2
`define FEBO_OFF_FMC_LO 4'h3
`define FEBO_OFF_FMC_HI 4'h4
`define FEBO_OFF_MODE_MON 4'h5

// Reset values and overlay reserved read bits
`define FEBO_EBSEL_RST 8'h00
`define FEBO_OVL_RST 8'hF0
`define FEBO_OVL_RSVD 8'hF0

// Lower flash mode control fields
`define FEBO_FMC_PINLVL 7
`define FEBO_FMC_SWE 6
// Upper flash mode control fields
`define FEBO_FMC_PSU 4
`define FEBO_FMC_PRG 0

// Overlay control fields
`define FEBO_OVL_SEL 3

// Upper select split: bits 11..8 and 15..12 of the combined vector
`define FEBO_HI_LOWER_NIB 4'h0

// Block geometry: small and big block sizes in address bits, mid block bounds as addresses
`define FEBO_SMALL_BLK_BITS 12
`define FEBO_MID_BLK_BASE 24'h008000
`define FEBO_MID_BLK_END 24'h00FFFF
`define FEBO_BIG_BLK_BITS 16

`endif

// File: febo_pkg.sv
package febo_pkg;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } febo_bus_req_t;

   typedef enum logic [1:0] {
      FEBO_MODE_NONE,
      FEBO_MODE_BOOT,
      FEBO_MODE_USERPROG
   } febo_pgm_mode_t;

   typedef struct packed {
      logic mode_pin_top;
      logic mode_pin_mid;
      logic mode_pin_low;
   } febo_mode_pins_t;
endpackage

// File: febo_ctrl.sv
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "febo_defs.svh"

// What this block does, and what software and the system must do
// [RL1] Upper program-mode bit sets only with pin high, upper enable and upper setup set.
// [RL2] Software should not touch flash while upper program-mode bit is set.
// [RL3] A set erase-select bit unprotects its block; clear bits keep blocks protected.
// [RL4] Lower select clears on reset, standby, pin low, or pin high with lower enable clear.
// [RL5] More than one select bit set across both registers clears both registers.
// [RL6] With flash disabled, select registers read zero and ignore writes.
// [RL7] Upper select clears on reset, standby, or write-protect pin low.
// [RL8] Upper bits 11-8 need lower enable; bits 15-12 need upper enable.
// [RL9] Blocks 0-7 are 4 KB, block 8 is 32 KB, blocks 9-15 are 64 KB.
// [RL10] Overlay control resets to F0 on power-on and hardware standby only.
// [RL11] Overlay control upper four bits always read one.
// [RL12] Overlay select set protects every flash block from program and erase; the code clears eraseAllowed only and leaves programModeUpper free.
// [RL13] With overlay on, area bits pick which 4 KB block the RAM window covers.
// [RL14] Software should not access emulated region right after overlay change.
// [RL15] Software should write overlay control only in user or user program mode.
// [RL16] Reset-start with programming pins enters a program/erase/verify state.
// [RL17] Pin high needed; top pin picks boot or user program; low pins pick 5-7.
// [RL18] In boot mode the system drives top pin inverted from its normal setting.
// [RL19] Mode monitor register reports mode 5, 6 or 7 in boot mode too.
// [RL20] Write-protect status bit reads pin level; low means hardware protected.
module febo_ctrl (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Standby and flash enable
   input wire logic hwStandby,
   input wire logic swStandby,
   input wire logic flashEnable,
   // Pins
   input wire logic writeProtectPin,
   input wire febo_pkg::febo_mode_pins_t modePins,
   // Register port
   input wire febo_pkg::febo_bus_req_t busReq,
   output logic [7:0] rdData,
   // Flash array address under test
   input wire logic [23:0] flashAddr,
   // Status to the flash array
   output logic [15:0] eraseAllowed,
   output logic addrEraseOk,
   output logic programModeUpper,
   output logic overlayActive,
   output logic [23:0] overlayBase,
   output febo_pkg::febo_pgm_mode_t pgmMode
);

   logic [7:0] fmcLo_ff;
   logic [7:0] fmcHi_ff;
   logic [7:0] ebLo_ff;
   logic [7:0] ebHi_ff;
   logic [3:0] ovl_ff;
   logic [1:0] modeMon_ff;
   febo_pkg::febo_pgm_mode_t pgmMode_ff;
   logic [7:0] rdData_ff;
   logic [7:0] nxt_rdData;
   logic [7:0] nxt_ebLo;
   logic [7:0] nxt_ebHi;
   logic [15:0] ebAll;
   logic [15:0] blkHit;
   logic sweLo;
   logic sweHi;
   logic standby;
   logic wrEbLo;
   logic wrEbHi;
   logic wrFmcLo;
   logic wrFmcHi;
   logic wrOvl;
   logic multi;

   assign sweLo = fmcLo_ff[`FEBO_FMC_SWE];
   assign sweHi = fmcHi_ff[`FEBO_FMC_SWE];
   assign standby = hwStandby | swStandby;
   assign wrEbLo = busReq.wr && busReq.addr == `FEBO_OFF_EBSEL_LO && flashEnable; // see [RL6]
   assign wrEbHi = busReq.wr && busReq.addr == `FEBO_OFF_EBSEL_HI && flashEnable; // see [RL6]
   assign wrFmcLo = busReq.wr && busReq.addr == `FEBO_OFF_FMC_LO && flashEnable;
   assign wrFmcHi = busReq.wr && busReq.addr == `FEBO_OFF_FMC_HI && flashEnable;
   assign wrOvl = busReq.wr && busReq.addr == `FEBO_OFF_OVL_CTRL;

   // Lower flash mode control: only the software enable is kept here
   always_ff @(posedge sys_clk) begin
      if (!nrst || standby || !writeProtectPin) begin
         fmcLo_ff <= 8'h00;
      end else if (wrFmcLo) begin
         fmcLo_ff <= {1'b0, busReq.wdata[`FEBO_FMC_SWE], 6'h00};
      end
   end

   // Upper flash mode control: enable, program setup and program-mode bits
   always_ff @(posedge sys_clk) begin
      if (!nrst || standby || !writeProtectPin) begin
         fmcHi_ff <= 8'h00;
      end else if (wrFmcHi) begin
         fmcHi_ff[`FEBO_FMC_SWE] <= busReq.wdata[`FEBO_FMC_SWE];
         fmcHi_ff[`FEBO_FMC_PSU] <= busReq.wdata[`FEBO_FMC_PSU] & sweHi;
         fmcHi_ff[`FEBO_FMC_PRG] <= busReq.wdata[`FEBO_FMC_PRG] & sweHi
            & fmcHi_ff[`FEBO_FMC_PSU]; // see [RL1]
      end
   end

   // Erase select next state with one-hot enforcement
   always_comb begin
      nxt_ebLo = ebLo_ff;
      nxt_ebHi = ebHi_ff;
      if (wrEbLo) begin
         nxt_ebLo = busReq.wdata;
      end
      if (wrEbHi) begin
         nxt_ebHi = busReq.wdata;
      end
      if (!sweLo) begin
         nxt_ebLo = `FEBO_EBSEL_RST; // see [RL4]
         nxt_ebHi[3:0] = `FEBO_HI_LOWER_NIB; // see [RL8]
      end
      if (!sweHi) begin
         nxt_ebHi[7:4] = `FEBO_HI_LOWER_NIB; // see [RL8]
      end
      multi = ($countones({nxt_ebHi, nxt_ebLo}) > 1);
      if (multi) begin
         nxt_ebLo = `FEBO_EBSEL_RST; // see [RL5]
         nxt_ebHi = `FEBO_EBSEL_RST; // see [RL5]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst || standby || !writeProtectPin) begin
         ebLo_ff <= `FEBO_EBSEL_RST; // see [RL4]
         ebHi_ff <= `FEBO_EBSEL_RST; // see [RL7]
      end else begin
         ebLo_ff <= nxt_ebLo;
         ebHi_ff <= nxt_ebHi;
      end
   end

   // Overlay control survives software standby; hardware standby resets it
   always_ff @(posedge sys_clk) begin
      if (!nrst || hwStandby) begin
         ovl_ff <= 4'(`FEBO_OVL_RST); // see [RL10]
      end else if (wrOvl) begin
         ovl_ff <= busReq.wdata[3:0];
      end
   end

   // Mode pins caught at reset release (reset-start)
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         modeMon_ff <= {modePins.mode_pin_mid, modePins.mode_pin_low};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         if (writeProtectPin && {modePins.mode_pin_mid, modePins.mode_pin_low} != 2'h0) begin
            pgmMode_ff <= modePins.mode_pin_top ? febo_pkg::FEBO_MODE_USERPROG
               : febo_pkg::FEBO_MODE_BOOT; // see [RL16] see [RL17]
         end else begin
            pgmMode_ff <= febo_pkg::FEBO_MODE_NONE;
         end
      end
   end

   // Read mux; a disabled flash hides the flash control registers
   always_comb begin
      nxt_rdData = 8'h00;
      if (busReq.rd) begin
         case (busReq.addr)
            `FEBO_OFF_EBSEL_LO: nxt_rdData = flashEnable ? ebLo_ff : 8'h00; // see [RL6]
            `FEBO_OFF_EBSEL_HI: nxt_rdData = flashEnable ? ebHi_ff : 8'h00; // see [RL6]
            `FEBO_OFF_OVL_CTRL: nxt_rdData = `FEBO_OVL_RSVD | {4'h0, ovl_ff}; // see [RL11]
            `FEBO_OFF_FMC_LO: nxt_rdData = flashEnable
               ? (fmcLo_ff | {writeProtectPin, 7'h00}) : 8'h00; // see [RL20]
            `FEBO_OFF_FMC_HI: nxt_rdData = flashEnable ? fmcHi_ff : 8'h00;
            `FEBO_OFF_MODE_MON: nxt_rdData = {5'h00, 1'b1, modeMon_ff}; // see [RL19]
            default: nxt_rdData = 8'h00;
         endcase
      end
   end

   // Read port, data one cycle after the strobe and zero otherwise
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rdData_ff <= 8'h00;
      end else begin
         rdData_ff <= nxt_rdData;
      end
   end

   assign ebAll = {ebHi_ff, ebLo_ff};

   // Block address decode
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_blk
         if (gi < 8) begin : g_small
            assign blkHit[gi] = flashAddr[23:`FEBO_SMALL_BLK_BITS] == 12'(gi); // see [RL9]
         end else if (gi == 8) begin : g_mid
            assign blkHit[gi] = flashAddr >= `FEBO_MID_BLK_BASE
               && flashAddr <= `FEBO_MID_BLK_END; // see [RL9]
         end else begin : g_big
            assign blkHit[gi] = flashAddr[23:`FEBO_BIG_BLK_BITS] == 8'(gi - 8); // see [RL9]
         end
         assign eraseAllowed[gi] = ebAll[gi] & ~ovl_ff[`FEBO_OVL_SEL]; // see [RL3] see [RL12]
      end
   endgenerate

   assign addrEraseOk = |(blkHit & eraseAllowed); // see [RL3]
   assign rdData = rdData_ff;
   assign programModeUpper = fmcHi_ff[`FEBO_FMC_PRG];
   assign overlayActive = ovl_ff[`FEBO_OVL_SEL]; // see [RL13]
   assign overlayBase = ovl_ff[`FEBO_OVL_SEL]
      ? {9'h000, ovl_ff[2:0], 12'h000} : 24'hFFE000; // see [RL13]
   assign pgmMode = pgmMode_ff;

   AST_P2_NEEDS_SETUP: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(programModeUpper) |-> $past(fmcHi_ff[`FEBO_FMC_PSU]) && $past(sweHi)
      && writeProtectPin) else $error("program mode set without setup"); // see [RL1]
   AST_ONEHOT: assert property (@(posedge sys_clk) disable iff (!nrst)
      $countones(ebAll) <= 1) else $error("erase select not one-hot"); // see [RL5]
   AST_LO_NOSWE: assert property (@(posedge sys_clk) disable iff (!nrst)
      !sweLo |=> ebLo_ff == 8'h00) else $error("lower select kept without enable"); // see [RL4]
   AST_HI_NIBBLES: assert property (@(posedge sys_clk) disable iff (!nrst)
      (!sweHi |=> ebHi_ff[7:4] == 4'h0)) else $error("upper nibble kept"); // see [RL8]
   AST_PIN_LOW: assert property (@(posedge sys_clk) disable iff (!nrst)
      !writeProtectPin |=> ebAll == 16'h0000) else $error("select kept with pin low"); // see [RL7]
   AST_DISABLED_RD: assert property (@(posedge sys_clk) disable iff (!nrst)
      busReq.rd && !flashEnable && busReq.addr == `FEBO_OFF_EBSEL_HI |=> rdData == 8'h00)
      else $error("disabled read not zero"); // see [RL6]
   AST_OVL_RSVD: assert property (@(posedge sys_clk) disable iff (!nrst)
      busReq.rd && busReq.addr == `FEBO_OFF_OVL_CTRL |=> rdData[7:4] == 4'hF)
      else $error("reserved bits not one"); // see [RL11]
   AST_OVL_PROT: assert property (@(posedge sys_clk) disable iff (!nrst)
      overlayActive |-> eraseAllowed == 16'h0000) else $error("erase open in overlay"); // see [RL12]
   AST_SW_STBY_KEEP: assert property (@(posedge sys_clk) disable iff (!nrst)
      swStandby && !hwStandby && !busReq.wr |=> $stable(ovl_ff))
      else $error("overlay lost in standby"); // see [RL10]

   // Further checks on what the block drives
   AST_LO_RD_DIS: assert property (@(posedge sys_clk) disable iff (!nrst)
      busReq.rd && !flashEnable && busReq.addr == `FEBO_OFF_EBSEL_LO |=> rdData == 8'h00)
      else $error("disabled lower read not zero"); // see [RL6]
   AST_HW_STBY_OVL: assert property (@(posedge sys_clk) disable iff (!nrst)
      hwStandby |=> ovl_ff == 4'h0)
      else $error("overlay kept in hardware standby"); // see [RL10]
   AST_OVL_WR: assert property (@(posedge sys_clk) disable iff (!nrst)
      wrOvl && !hwStandby |=> overlayActive == $past(busReq.wdata[`FEBO_OVL_SEL]))
      else $error("overlay select not written"); // see [RL12]
   AST_STBY_CLR: assert property (@(posedge sys_clk) disable iff (!nrst)
      standby |=> ebAll == 16'h0000)
      else $error("select kept in standby"); // see [RL4] see [RL7]
   AST_FMC_PIN: assert property (@(posedge sys_clk) disable iff (!nrst)
      !writeProtectPin |=> !sweLo && !sweHi && !programModeUpper)
      else $error("mode control kept with pin low"); // see [RL1]
   AST_PSU_NEEDS_SWE: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(fmcHi_ff[`FEBO_FMC_PSU]) |-> $past(sweHi))
      else $error("setup set without enable"); // see [RL1]
   AST_ERASE_SUB: assert property (@(posedge sys_clk) disable iff (!nrst)
      (eraseAllowed & ~ebAll) == 16'h0000)
      else $error("erase open on unselected block"); // see [RL3]
   AST_ADDR_OK: assert property (@(posedge sys_clk) disable iff (!nrst)
      addrEraseOk |-> (blkHit & ebAll) != 16'h0000)
      else $error("address erase without selection"); // see [RL3]
   AST_MULTI_CLR: assert property (@(posedge sys_clk) disable iff (!nrst)
      multi && !standby && writeProtectPin |=> ebAll == 16'h0000)
      else $error("multiple selects not cleared"); // see [RL5]
   AST_HI_LOW_NIB: assert property (@(posedge sys_clk) disable iff (!nrst)
      !sweLo |=> ebHi_ff[3:0] == 4'h0)
      else $error("upper low nibble kept"); // see [RL8]
   AST_BLK8: assert property (@(posedge sys_clk) disable iff (!nrst)
      flashAddr >= `FEBO_MID_BLK_BASE && flashAddr <= `FEBO_MID_BLK_END |-> blkHit == 16'h0100)
      else $error("mid block decode wrong"); // see [RL9]
   AST_BLK_ONEHOT: assert property (@(posedge sys_clk) disable iff (!nrst)
      $countones(blkHit) <= 1)
      else $error("address in two blocks"); // see [RL9]
   AST_OVL_OFF_BASE: assert property (@(posedge sys_clk) disable iff (!nrst)
      !overlayActive |-> overlayBase == 24'hFFE000)
      else $error("window moved with overlay off"); // see [RL13]
   AST_OVL_ON_BASE: assert property (@(posedge sys_clk) disable iff (!nrst)
      overlayActive |-> overlayBase[23:15] == 9'h000 && overlayBase[11:0] == 12'h000)
      else $error("window outside small blocks"); // see [RL13]
   AST_OVL_RD_LOW: assert property (@(posedge sys_clk) disable iff (!nrst)
      busReq.rd && busReq.addr == `FEBO_OFF_OVL_CTRL |=> rdData[3:0] == $past(ovl_ff))
      else $error("overlay read back wrong"); // see [RL13]
   AST_PIN_STATUS: assert property (@(posedge sys_clk) disable iff (!nrst)
      busReq.rd && flashEnable && busReq.addr == `FEBO_OFF_FMC_LO
      |=> rdData[7] == $past(writeProtectPin)) else $error("pin status wrong"); // see [RL20]
   AST_MODE_MON: assert property (@(posedge sys_clk) disable iff (!nrst)
      busReq.rd && busReq.addr == `FEBO_OFF_MODE_MON |=> rdData[2] == 1'b1)
      else $error("mode monitor fixed bit wrong"); // see [RL19]

   // Main scenarios

   COV_ERASE_SEL: cover property (@(posedge sys_clk) disable iff (!nrst) addrEraseOk);
   COV_MULTI_CLR: cover property (@(posedge sys_clk) disable iff (!nrst) wrEbLo && multi);
   COV_OVERLAY: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(overlayActive));
   COV_PROG: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(programModeUpper));
   COV_HW_STBY: cover property (@(posedge sys_clk) disable iff (!nrst) hwStandby);

endmodule

// File: febo_cpu_model.sv
`timescale 1ns/1ps
// Stands in for the CPU: each call launches one bus cycle just after a rising edge
module febo_cpu_model (
   // Clock
   input wire logic sys_clk,
   // Register port
   output febo_pkg::febo_bus_req_t busReq
);
   initial busReq = '0;
   // Flash is never touched while the upper program bit is set
   // Flash is never touched right after an overlay change
   // Overlay writes only follow a user program mode reset-start
   task automatic access(input logic [3:0] a, input logic [7:0] d, input logic w,
                         input logic r);
      @(posedge sys_clk);
      busReq <= {a, d, w, r};
   endtask
endmodule

// File: febo_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("FAIL %s expected %h seen %h", nm, e, g); end end
module febo_ctrl_tb;
   logic sys_clk = 0, nrst = 0, hwStandby = 0, swStandby = 0, flashEnable = 1;
   logic writeProtectPin = 1, rdTaken = 0, addrEraseOk, programModeUpper, overlayActive;
   febo_pkg::febo_mode_pins_t modePins = '0;
   febo_pkg::febo_bus_req_t busReq;
   febo_pkg::febo_pgm_mode_t pgmMode, em;
   logic [23:0] flashAddr = '0, overlayBase;
   logic [15:0] eraseAllowed;
   logic [7:0] rdData, expV, expQ[$];
   logic [2:0] p;
   int n_errors = 0, checked = 0;
   int unsigned b;
   always #25 sys_clk = ~sys_clk;
   febo_cpu_model i_cpu (.sys_clk(sys_clk), .busReq(busReq));
   febo_ctrl i_dut (.sys_clk(sys_clk), .nrst(nrst), .hwStandby(hwStandby),
      .swStandby(swStandby), .flashEnable(flashEnable), .writeProtectPin(writeProtectPin),
      .modePins(modePins), .busReq(busReq), .rdData(rdData), .flashAddr(flashAddr),
      .eraseAllowed(eraseAllowed), .addrEraseOk(addrEraseOk),
      .programModeUpper(programModeUpper), .overlayActive(overlayActive),
      .overlayBase(overlayBase), .pgmMode(pgmMode));
   // Read data stand only in the cycle after the read was taken
   always @(posedge sys_clk) rdTaken <= busReq.rd;
   always @(negedge sys_clk) if (rdTaken) begin
      expV = expQ.pop_front();
      `CHK("rdData", expV, rdData)
   end
   task automatic w(input logic [3:0] a, input logic [7:0] d);
      i_cpu.access(a, d, 1'b1, 1'b0);
   endtask
   task automatic r(input logic [3:0] a, input logic [7:0] e);
      expQ.push_back(e);
      i_cpu.access(a, 8'h00, 1'b0, 1'b1);
   endtask
   task automatic settle();
      i_cpu.access(4'h0, 8'h00, 1'b0, 1'b0);
      @(negedge sys_clk);
   endtask
   // One-cycle event: 0 pin low, 1 software standby, 2 hardware standby
   task automatic pulse(input int which);
      @(posedge sys_clk);
      if (which == 0) writeProtectPin <= 1'b0;
      else if (which == 1) swStandby <= 1'b1;
      else hwStandby <= 1'b1;
      @(posedge sys_clk);
      writeProtectPin <= 1'b1;
      swStandby <= 1'b0;
      hwStandby <= 1'b0;
      settle();
   endtask
   task automatic drvAddr(input logic [23:0] a);
      @(posedge sys_clk) flashAddr <= a;
      @(negedge sys_clk);
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   function automatic logic [23:0] blkBase(input int unsigned k);
      return k < 8 ? 24'(k * 4096) : k == 8 ? 24'h008000 : 24'((k - 8) * 65536);
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_errors++;
      summarize();
   end
   initial begin
      void'($urandom(56891));
      // Boot mode takes the top pin low
      for (int i = 0; i < 9; i++) begin
         p = (i == 0) ? 3'($urandom) : 3'(i - 1);
         @(posedge sys_clk);
         writeProtectPin <= (i != 0);
         nrst <= 1'b0;
         modePins <= p;
         repeat (4) @(posedge sys_clk);
         nrst <= 1'b1;
         settle();
         em = (i == 0 || p[1:0] == 2'b00) ? febo_pkg::FEBO_MODE_NONE :
              p[2] ? febo_pkg::FEBO_MODE_USERPROG : febo_pkg::FEBO_MODE_BOOT;
         `CHK("pgmMode", em, pgmMode)
         r(4'h5, {5'h00, 1'b1, p[1:0]});
         settle();
      end
      done("modes");
      r(4'h0, 8'h00);
      r(4'h1, 8'h00);
      r(4'h2, 8'hF0);
      r(4'h3, 8'h80);
      r(4'hF, 8'h00);
      w(4'h3, 8'h40);
      w(4'h4, 8'h40);
      for (b = 0; b < 16; b++) begin
         w(4'h0, 8'h00);
         w(4'h1, 8'h00);
         w(b < 8 ? 4'h0 : 4'h1, 8'(1 << (b % 8)));
         settle();
         drvAddr(blkBase(b) | 24'($urandom % 4096));
         `CHK("eraseAllowed", 16'(1 << b), eraseAllowed)
         `CHK("addrEraseOk", 1'b1, addrEraseOk)
         drvAddr(blkBase((b + 1) % 16));
         `CHK("addrEraseOk", 1'b0, addrEraseOk)
      end
      w(4'h0, 8'h01);
      settle();
      r(4'h0, 8'h00);
      r(4'h1, 8'h00);
      w(4'h4, 8'h00);
      w(4'h1, 8'h10);
      settle();
      r(4'h1, 8'h00);
      w(4'h1, 8'h01);
      w(4'h3, 8'h00);
      settle();
      r(4'h1, 8'h00);
      w(4'h3, 8'h40);
      w(4'h0, 8'h02);
      w(4'h3, 8'h00);
      settle();
      r(4'h0, 8'h00);
      done("selects");
      w(4'h4, 8'h40);
      w(4'h4, 8'h41);
      settle();
      `CHK("programModeUpper", 1'b0, programModeUpper)
      w(4'h4, 8'h50);
      w(4'h4, 8'h51);
      settle();
      `CHK("programModeUpper", 1'b1, programModeUpper)
      w(4'h1, 8'h80);
      settle();
      pulse(0);
      `CHK("programModeUpper", 1'b0, programModeUpper)
      r(4'h1, 8'h00);
      w(4'h3, 8'h40);
      w(4'h0, 8'h04);
      for (int k = 0; k < 8; k++) begin
         w(4'h2, 8'(8 + k));
         settle();
         `CHK("overlayActive", 1'b1, overlayActive)
         `CHK("eraseAllowed", 16'h0000, eraseAllowed)
         `CHK("overlayBase", 24'(k * 4096), overlayBase)
         r(4'h2, 8'(8'hF8 + k));
      end
      w(4'h2, 8'h05);
      settle();
      `CHK("overlayBase", 24'hFFE000, overlayBase)
      `CHK("eraseAllowed", 16'h0004, eraseAllowed)
      done("overlay");
      w(4'h2, 8'h0B);
      settle();
      pulse(1);
      r(4'h2, 8'hFB);
      r(4'h0, 8'h00);
      settle();
      pulse(2);
      r(4'h2, 8'hF0);
      w(4'h3, 8'h40);
      settle();
      @(posedge sys_clk) flashEnable <= 1'b0;
      w(4'h0, 8'h01);
      r(4'h0, 8'h00);
      settle();
      @(posedge sys_clk) flashEnable <= 1'b1;
      r(4'h0, 8'h00);
      settle();
      settle();
      done("standby");
      summarize();
   end
endmodule
